// file: core/cfm_consts.svh
// Constants of the charger interrupt mask block: offsets, fields, resets.
// Assumes inclusion by bare name from every file that needs them.
`ifndef CFM_CONSTS_SVH
`define CFM_CONSTS_SVH

// Register offsets on the serial register port
`define CFM_OFF_TEMP_OTG_MASK 8'h2b
`define CFM_OFF_FAULT_MASK 8'h2c

// Reset values; the temperature register holds five live bits
`define CFM_TEMP_MASK_RST 5'h00
`define CFM_FAULT_MASK_RST 8'h00

// Event index; also the bit position inside the temperature register
`define CFM_EV_HOT 0
`define CFM_EV_WARM 1
`define CFM_EV_COOL 2
`define CFM_EV_COLD 3
`define CFM_EV_OTG_LOW 4
// Fault events sit at fault register bit plus five
`define CFM_EV_VIN1_OVP 5
`define CFM_EV_VIN2_OVP 6
`define CFM_EV_SW_OCP 7
`define CFM_EV_BAT_OCP 8
`define CFM_EV_IN_OCP 9
`define CFM_EV_BAT_OVP 10
`define CFM_EV_BUS_OVP 11
`define CFM_EV_CHG_LIM 12
`define CFM_EV_N 13
// Events that fire on both entry and exit
`define CFM_EV_BOTH_EDGES 13'h100f

// Interrupt pulse length in ref_clk cycles
`define CFM_IRQ_PULSE_CYC 4'h8
// Serial bus device address, value arbitrary
`define CFM_I2C_ADDR 7'h35

`endif

// file: core/cfm_pkg.sv
// Types of the charger interrupt mask block.
// Assumes nothing beyond a SystemVerilog compiler.
package cfm_pkg;

    // Serial register port sequencer states
    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_ADDR = 4'h1,
        ST_ADDR_ACK = 4'h2,
        ST_PTR = 4'h3,
        ST_PTR_ACK = 4'h4,
        ST_WDATA = 4'h5,
        ST_WDATA_ACK = 4'h6,
        ST_RDATA = 4'h7,
        ST_RDATA_ACK = 4'h8,
        ST_SKIP = 4'h9
    } cfm_i2c_state_e;

endpackage

// file: core/cfm_sync2.sv
// Two flip-flop synchroniser for pins and comparator levels.
// Assumes inputs are asynchronous to ref_clk; only stage two is read.
`timescale 1ns/100ps
`default_nettype none
module cfm_sync2 #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Levels
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);

    logic [W-1:0] meta_q;
    logic [W-1:0] meta_d;
    logic [W-1:0] dout_d;

    // Next values of both stages
    always_comb begin
        meta_d = din;
        dout_d = meta_q;
    end

    // Stage registers
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            meta_q <= RST_VAL;
            dout <= RST_VAL;
        end else begin
            meta_q <= meta_d;
            dout <= dout_d;
        end
    end

endmodule
`default_nettype wire

// file: core/cfm_irq_mask_ctl.sv
// Interrupt mask registers of a charger with their serial register port.
// Assumes a host bus master on scl/sda with an external pull-up, and
// comparator levels arriving asynchronously.
`include "cfm_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module cfm_irq_mask_ctl (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Serial register port
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    // Register resets from the same clock domain
    input wire logic softRegReset,
    input wire logic hostCommTimeout,
    // Comparator levels, asynchronous
    input wire logic thermistorSenseCold,
    input wire logic thermistorSenseCool,
    input wire logic thermistorSenseWarm,
    input wire logic thermistorSenseHot,
    input wire logic otgBattLow,
    input wire logic chargeCurrentLimit,
    input wire logic inputBusOvervolt,
    input wire logic batteryOvervolt,
    input wire logic inputOvercurrent,
    input wire logic batteryOvercurrent,
    input wire logic switcherOvercurrent,
    input wire logic secondInputOvervolt,
    input wire logic firstInputOvervolt,
    // Host interrupt and event pulses of every event, masked or not
    output logic hostIrqPin_n,
    output logic [`CFM_EV_N-1:0] eventPulse
);

    // Register read decode, reserved bits as zero
    function automatic logic [7:0] regRead(input logic [7:0] a,
                                           input logic [4:0] t,
                                           input logic [7:0] f);
        case (a)
            `CFM_OFF_TEMP_OTG_MASK: regRead = {3'h0, t};
            `CFM_OFF_FAULT_MASK: regRead = f;
            default: regRead = 8'h00;
        endcase
    endfunction

    logic scl;
    logic sda;
    logic sclPrev_q;
    logic sdaPrev_q;
    logic sclRise;
    logic sclFall;
    logic startCond;
    logic stopCond;
    cfm_pkg::cfm_i2c_state_e st_q;
    cfm_pkg::cfm_i2c_state_e st_d;
    logic [3:0] bitCnt_q;
    logic [3:0] bitCnt_d;
    logic [7:0] shift_q;
    logic [7:0] shift_d;
    logic [7:0] ptr_q;
    logic [7:0] ptr_d;
    logic rw_q;
    logic rw_d;
    logic sdaOe_q;
    logic sdaOe_d;
    logic wrStb;
    logic [7:0] rdByte;
    logic [4:0] tempMask_q;
    logic [4:0] tempMask_d;
    logic [7:0] faultMask_q;
    logic [7:0] faultMask_d;
    logic [`CFM_EV_N-1:0] lvlSync;
    logic [`CFM_EV_N-1:0] lvlPrev_q;
    logic [`CFM_EV_N-1:0] evt;
    logic [`CFM_EV_N-1:0] maskVec;
    logic [`CFM_EV_N-1:0] eventPulse_q;
    logic primed_q;
    logic fire;
    logic [3:0] irqCnt_q;
    logic [3:0] irqCnt_d;
    logic irqN_q;

    // Bus pins idle high after reset
    cfm_sync2 #(.W(2), .RST_VAL(2'h3)) u_pinSync (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .din({sclIn, sdaIn}),
        .dout({scl, sda})
    );

    // Comparator levels in event index order
    cfm_sync2 #(.W(`CFM_EV_N), .RST_VAL(13'h0000)) u_evSync (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .din({chargeCurrentLimit, inputBusOvervolt, batteryOvervolt,
              inputOvercurrent, batteryOvercurrent, switcherOvercurrent,
              secondInputOvervolt, firstInputOvervolt, otgBattLow,
              thermistorSenseCold, thermistorSenseCool,
              thermistorSenseWarm, thermistorSenseHot}),
        .dout(lvlSync)
    );

    // Bus line edges and start/stop conditions
    assign sclRise = scl & ~sclPrev_q;
    assign sclFall = ~scl & sclPrev_q;
    assign startCond = scl & sclPrev_q & sdaPrev_q & ~sda;
    assign stopCond = scl & sclPrev_q & ~sdaPrev_q & sda;
    assign rdByte = regRead(ptr_q, tempMask_q, faultMask_q);

    // Serial sequencer: address, pointer, then write or read bytes
    always_comb begin
        st_d = st_q;
        bitCnt_d = bitCnt_q;
        shift_d = shift_q;
        ptr_d = ptr_q;
        rw_d = rw_q;
        sdaOe_d = sdaOe_q;
        wrStb = 1'b0;
        if (stopCond) begin
            st_d = cfm_pkg::ST_IDLE;
            sdaOe_d = 1'b0;
        end else if (startCond) begin
            st_d = cfm_pkg::ST_ADDR;
            bitCnt_d = 4'h0;
            sdaOe_d = 1'b0;
        end else begin
            case (st_q)
                cfm_pkg::ST_ADDR, cfm_pkg::ST_PTR, cfm_pkg::ST_WDATA: begin
                    if (sclRise && bitCnt_q != 4'h8) begin
                        shift_d = {shift_q[6:0], sda};
                        bitCnt_d = 4'(bitCnt_q + 4'h1);
                    end else if (sclFall && bitCnt_q == 4'h8) begin
                        bitCnt_d = 4'h0;
                        sdaOe_d = 1'b1;
                        if (st_q == cfm_pkg::ST_ADDR) begin
                            rw_d = shift_q[0];
                            st_d = cfm_pkg::ST_ADDR_ACK;
                            if (shift_q[7:1] != `CFM_I2C_ADDR) begin
                                st_d = cfm_pkg::ST_SKIP;
                                sdaOe_d = 1'b0;
                            end
                        end else if (st_q == cfm_pkg::ST_PTR) begin
                            ptr_d = shift_q;
                            st_d = cfm_pkg::ST_PTR_ACK;
                        end else begin
                            wrStb = 1'b1;
                            st_d = cfm_pkg::ST_WDATA_ACK;
                        end
                    end
                end
                // Acknowledge slot; also reloads the next read byte
                cfm_pkg::ST_ADDR_ACK, cfm_pkg::ST_PTR_ACK,
                cfm_pkg::ST_WDATA_ACK: begin
                    if (sclFall) begin
                        if (st_q == cfm_pkg::ST_ADDR_ACK && rw_q) begin
                            sdaOe_d = ~rdByte[7];
                            shift_d = {rdByte[6:0], 1'b0};
                            bitCnt_d = 4'h1;
                            st_d = cfm_pkg::ST_RDATA;
                        end else begin
                            sdaOe_d = 1'b0;
                            bitCnt_d = 4'h0;
                            st_d = (st_q == cfm_pkg::ST_ADDR_ACK) ?
                                   cfm_pkg::ST_PTR : cfm_pkg::ST_WDATA;
                            if (st_q == cfm_pkg::ST_WDATA_ACK) begin
                                ptr_d = 8'(ptr_q + 8'h01);
                            end
                        end
                    end
                end
                cfm_pkg::ST_RDATA: begin
                    if (sclFall) begin
                        if (bitCnt_q == 4'h8) begin
                            sdaOe_d = 1'b0;
                            st_d = cfm_pkg::ST_RDATA_ACK;
                        end else begin
                            sdaOe_d = ~shift_q[7];
                            shift_d = {shift_q[6:0], 1'b0};
                            bitCnt_d = 4'(bitCnt_q + 4'h1);
                        end
                    end
                end
                // Master ack continues the read, nack ends it
                cfm_pkg::ST_RDATA_ACK: begin
                    if (sclRise) begin
                        if (sda) begin
                            st_d = cfm_pkg::ST_SKIP;
                        end else begin
                            ptr_d = 8'(ptr_q + 8'h01);
                            st_d = cfm_pkg::ST_ADDR_ACK;
                        end
                    end
                end
                cfm_pkg::ST_IDLE, cfm_pkg::ST_SKIP: begin
                    st_d = st_q;
                end
                default: begin
                    st_d = cfm_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Sequencer registers
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            st_q <= cfm_pkg::ST_IDLE;
            bitCnt_q <= 4'h0;
            shift_q <= 8'h00;
            ptr_q <= 8'h00;
            rw_q <= 1'b0;
            sdaOe_q <= 1'b0;
            sclPrev_q <= 1'b1;
            sdaPrev_q <= 1'b1;
        end else begin
            st_q <= st_d;
            bitCnt_q <= bitCnt_d;
            shift_q <= shift_d;
            ptr_q <= ptr_d;
            rw_q <= rw_d;
            sdaOe_q <= sdaOe_d;
            sclPrev_q <= scl;
            sdaPrev_q <= sda;
        end
    end

    assign sdaOut = 1'b0;
    assign sdaOe = sdaOe_q;

    // Mask registers: soft reset clears both, timeout only temperature
    always_comb begin
        tempMask_d = tempMask_q;
        faultMask_d = faultMask_q;
        if (wrStb && ptr_q == `CFM_OFF_TEMP_OTG_MASK) begin
            tempMask_d = shift_q[4:0];
        end
        if (wrStb && ptr_q == `CFM_OFF_FAULT_MASK) begin
            faultMask_d = shift_q;
        end
        if (hostCommTimeout) begin
            tempMask_d = `CFM_TEMP_MASK_RST;
        end
        if (softRegReset) begin
            tempMask_d = `CFM_TEMP_MASK_RST;
            faultMask_d = `CFM_FAULT_MASK_RST;
        end
    end

    // Event detect and interrupt pulse timer
    always_comb begin
        maskVec = {faultMask_q, tempMask_q};
        evt = '0;
        if (primed_q) begin
            evt = (lvlSync & ~lvlPrev_q) |
                  (~lvlSync & lvlPrev_q & `CFM_EV_BOTH_EDGES);
        end
        fire = |(evt & ~maskVec);
        irqCnt_d = irqCnt_q;
        if (fire) begin
            irqCnt_d = `CFM_IRQ_PULSE_CYC;
        end else if (irqCnt_q != 4'h0) begin
            irqCnt_d = 4'(irqCnt_q - 4'h1);
        end
    end

    // Mask, event and timer registers
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            tempMask_q <= `CFM_TEMP_MASK_RST;
            faultMask_q <= `CFM_FAULT_MASK_RST;
            lvlPrev_q <= '0;
            primed_q <= 1'b0;
            eventPulse_q <= '0;
            irqCnt_q <= 4'h0;
            irqN_q <= 1'b1;
        end else begin
            tempMask_q <= tempMask_d;
            faultMask_q <= faultMask_d;
            lvlPrev_q <= lvlSync;
            primed_q <= 1'b1;
            eventPulse_q <= evt;
            irqCnt_q <= irqCnt_d;
            irqN_q <= (irqCnt_d == 4'h0);
        end
    end

    assign hostIrqPin_n = irqN_q;
    assign eventPulse = eventPulse_q;

    // Checks of the gating, pulse and reset behaviour
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    property p_cold;
        eventPulse_q[`CFM_EV_COLD] && !$past(tempMask_q[3]) |-> !hostIrqPin_n;
    endproperty
    a_cold: assert property (p_cold) else $error("cold lost");
    property p_cool;
        eventPulse_q[`CFM_EV_COOL] && !$past(tempMask_q[2]) |->
            irqCnt_q == 4'h8;
    endproperty
    a_cool: assert property (p_cool) else $error("cool lost");
    property p_warm;
        eventPulse_q[`CFM_EV_WARM] && !$past(tempMask_q[1]) |-> !hostIrqPin_n;
    endproperty
    a_warm: assert property (p_warm) else $error("warm lost");
    property p_hot_clear;
        hostCommTimeout |=> tempMask_q == 5'h00 ##0
            (ptr_q != `CFM_OFF_TEMP_OTG_MASK || rdByte[7:5] == 3'h0);
    endproperty
    a_hot_clear: assert property (p_hot_clear)
        else $error("timeout clear missed");
    property p_chg_exit;
        $past(primed_q) && $fell(lvlPrev_q[`CFM_EV_CHG_LIM]) ##0
            !$past(faultMask_q[7]) |-> ##1 !hostIrqPin_n;
    endproperty
    a_chg_exit: assert property (p_chg_exit)
        else $error("charge limit exit lost");
    property p_bus_keep;
        hostCommTimeout && !softRegReset && !wrStb |=>
            faultMask_q == $past(faultMask_q);
    endproperty
    a_bus_keep: assert property (p_bus_keep)
        else $error("fault mask cleared by timeout");
    property p_bat_ovp;
        eventPulse_q[`CFM_EV_BAT_OVP] && !$past(faultMask_q[5]) |->
            !hostIrqPin_n;
    endproperty
    a_bat_ovp: assert property (p_bat_ovp) else $error("ovp lost");
    property p_masked_only;
        (eventPulse_q & ~$past(maskVec)) == '0 && $past(irqCnt_q) == 4'h0
            |-> hostIrqPin_n;
    endproperty
    a_masked_only: assert property (p_masked_only)
        else $error("masked event fired");
    property p_pulse;
        $fell(hostIrqPin_n) |-> !hostIrqPin_n [*8];
    endproperty
    a_pulse: assert property (p_pulse) else $error("short pulse");
    property p_pulse_end;
        irqCnt_q == 4'h1 && !fire |=> hostIrqPin_n;
    endproperty
    a_pulse_end: assert property (p_pulse_end)
        else $error("pulse stuck");
    property p_temp_write;
        wrStb && ptr_q == `CFM_OFF_TEMP_OTG_MASK && !softRegReset &&
            !hostCommTimeout |=> tempMask_q == $past(shift_q[4:0]);
    endproperty
    a_temp_write: assert property (p_temp_write)
        else $error("temp write lost");
    property p_status;
        $past(primed_q && lvlSync[0] != lvlPrev_q[0]) |-> eventPulse_q[0];
    endproperty
    a_status: assert property (p_status) else $error("status lost");

    c_irq: cover property ($fell(hostIrqPin_n));
    c_masked: cover property (|eventPulse_q && hostIrqPin_n);
    c_wr_temp: cover property (wrStb && ptr_q == `CFM_OFF_TEMP_OTG_MASK);
    c_read: cover property (st_q == cfm_pkg::ST_RDATA_ACK);

endmodule
`default_nettype wire

// file: core/placeholder_none.sv
// Empty compilation unit of the charger interrupt mask block.
// Assumes nothing; it holds no module.
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

// file: test/cfm_host_model.sv
// Host bus master model for the serial register port of the mask block.
// Assumes the bench resolves the open-drain data wire with a pull-up.
`include "cfm_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module cfm_host_model #(
    parameter int HALF = 5
) (
    // Clock
    input wire logic ref_clk,
    // Bus wires
    output logic sclDrv,
    output logic sdaDrv,
    input wire logic sdaLine
);
    // Idle bus: both lines released high, clock stands still
    initial begin
        sclDrv = 1'b1;
        sdaDrv = 1'b1;
    end

    // Half a bus period
    task automatic hw();
        repeat (HALF) @(posedge ref_clk);
    endtask

    // Start or repeated start
    task automatic start();
        sdaDrv <= 1'b1;
        hw();
        sclDrv <= 1'b1;
        hw();
        sdaDrv <= 1'b0;
        hw();
        sclDrv <= 1'b0;
        @(posedge ref_clk);
    endtask

    // Stop condition
    task automatic stop();
        sdaDrv <= 1'b0;
        hw();
        sclDrv <= 1'b1;
        hw();
        sdaDrv <= 1'b1;
        hw();
    endtask

    // One bit; data moves only while the clock is low
    task automatic clk_bit(input logic b, output logic s);
        sdaDrv <= b;
        hw();
        sclDrv <= 1'b1;
        hw();
        s = sdaLine;
        sclDrv <= 1'b0;
        @(posedge ref_clk);
    endtask

    // Byte out, most significant bit first, then the acknowledge slot
    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(b[i], s);
        end
        clk_bit(1'b1, s);
        ack = ~s;
    endtask

    // Byte in; the last one is answered with a not-acknowledge
    task automatic recv_byte(input logic last, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(1'b1, s);
            d[i] = s;
        end
        clk_bit(last, s);
    endtask

    // Register write: address, pointer, data
    task automatic wr(input logic [6:0] dev, input logic [7:0] ptr,
                      input logic [7:0] dat, output logic ack);
        logic a1;
        logic a2;
        logic a3;
        start();
        send_byte({dev, 1'b0}, a1);
        send_byte(ptr, a2);
        send_byte(dat, a3);
        stop();
        ack = a1 & a2 & a3;
    endtask

    // Register read through a repeated start
    task automatic rd(input logic [7:0] ptr, output logic [7:0] dat);
        logic a;
        start();
        send_byte({`CFM_I2C_ADDR, 1'b0}, a);
        send_byte(ptr, a);
        start();
        send_byte({`CFM_I2C_ADDR, 1'b1}, a);
        recv_byte(1'b1, dat);
        stop();
    endtask

    // Two consecutive registers in one read, first byte acknowledged
    task automatic rd2(input logic [7:0] ptr, output logic [15:0] dat);
        logic a;
        start();
        send_byte({`CFM_I2C_ADDR, 1'b0}, a);
        send_byte(ptr, a);
        start();
        send_byte({`CFM_I2C_ADDR, 1'b1}, a);
        recv_byte(1'b0, dat[15:8]);
        recv_byte(1'b1, dat[7:0]);
        stop();
    endtask
endmodule
`default_nettype wire

// file: test/tb_charger_fault_irq_masks.sv
// Self-checking bench for the charger interrupt mask block.
// Assumes the host model drives the bus; comparator levels come from here.
`include "cfm_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module tb_charger_fault_irq_masks;
    localparam logic [7:0] TMP = `CFM_OFF_TEMP_OTG_MASK;
    localparam logic [7:0] FLT = `CFM_OFF_FAULT_MASK;
    logic ref_clk;
    logic rst_n;
    logic softRegReset;
    logic hostCommTimeout;
    logic [12:0] lvl;
    logic sclDrv;
    logic sdaDrv;
    logic sdaOut;
    logic sdaOe;
    logic hostIrqPin_n;
    logic [`CFM_EV_N-1:0] eventPulse;
    logic [4:0] tempM;
    logic [7:0] faultM;
    int errors;
    int check_count;
    wire logic sdaLine;

    // Open-drain data wire with pull-up
    assign sdaLine = ((sdaOe && !sdaOut) || !sdaDrv) ? 1'b0 : 1'b1;

    // Device under test
    cfm_irq_mask_ctl uut (
        .ref_clk(ref_clk), .rst_n(rst_n), .sclIn(sclDrv), .sdaIn(sdaLine),
        .sdaOut(sdaOut), .sdaOe(sdaOe), .softRegReset(softRegReset),
        .hostCommTimeout(hostCommTimeout),
        .thermistorSenseCold(lvl[3]), .thermistorSenseCool(lvl[2]),
        .thermistorSenseWarm(lvl[1]), .thermistorSenseHot(lvl[0]),
        .otgBattLow(lvl[4]), .chargeCurrentLimit(lvl[12]),
        .inputBusOvervolt(lvl[11]), .batteryOvervolt(lvl[10]),
        .inputOvercurrent(lvl[9]), .batteryOvercurrent(lvl[8]),
        .switcherOvercurrent(lvl[7]), .secondInputOvervolt(lvl[6]),
        .firstInputOvervolt(lvl[5]), .hostIrqPin_n(hostIrqPin_n),
        .eventPulse(eventPulse)
    );

    // Host on the far side of the bus
    cfm_host_model host (
        .ref_clk(ref_clk), .sclDrv(sclDrv), .sdaDrv(sdaDrv),
        .sdaLine(sdaLine)
    );

    // Clock
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    // Compare tasks
    task automatic cmp_reg(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] t=%0t reg got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cmp_cnt(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] t=%0t cnt got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cmp_ack(input logic got, input logic exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] t=%0t ack got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Verdict and end of run
    task automatic complete_run();
        $display("Checks %0d, mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Register access with the bench's own copy of the masks
    task automatic reg_wr(input logic [7:0] ptr, input logic [7:0] dat);
        logic ack;
        host.wr(`CFM_I2C_ADDR, ptr, dat, ack);
        cmp_ack(ack, 1'b1);
        if (ptr == TMP) tempM = dat[4:0];
        if (ptr == FLT) faultM = dat;
    endtask

    task automatic reg_chk(input logic [7:0] ptr, input logic [7:0] exp);
        logic [7:0] d;
        host.rd(ptr, d);
        cmp_reg(d, exp);
    endtask

    // Toggle one comparator level, count pulses and interrupt low cycles
    task automatic ev_chk(input int idx);
        logic rise;
        logic pulse;
        logic m;
        logic [7:0] nPulse;
        logic [7:0] nLow;
        logic [7:0] nOther;
        rise = ~lvl[idx];
        pulse = rise || idx < 4 || idx == 12;
        m = (idx < 5) ? tempM[idx] : faultM[idx - 5];
        nPulse = 8'h00;
        nLow = 8'h00;
        nOther = 8'h00;
        lvl[idx] <= rise;
        repeat (20) begin
            @(posedge ref_clk);
            #1;
            nPulse += {7'h00, eventPulse[idx]};
            nLow += {7'h00, !hostIrqPin_n};
            nOther += {7'h00, |(eventPulse & ~(13'h1 << idx))};
        end
        cmp_cnt(nPulse, pulse ? 8'h01 : 8'h00);
        cmp_cnt(nLow, (pulse && !m) ? 8'h08 : 8'h00);
        cmp_cnt(nOther, 8'h00);
    endtask

    // Watchdog about 1.7 times the expected run length of about 35000 cycles
    initial begin
        repeat (60000) @(posedge ref_clk);
        errors++;
        complete_run();
    end

    // Main sequence
    initial begin
        logic [7:0] r;
        logic ack;
        logic [15:0] w;
        rst_n = 1'b0;
        softRegReset = 1'b0;
        hostCommTimeout = 1'b0;
        lvl = '0;
        tempM = '0;
        faultM = '0;
        errors = 0;
        check_count = 0;
        void'($urandom(32'h7039));
        repeat (10) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (5) @(posedge ref_clk);
        reg_chk(TMP, 8'h00);
        reg_chk(FLT, 8'h00);
        reg_wr(TMP, 8'hff);
        reg_chk(TMP, 8'h1f);
        r = 8'($urandom);
        reg_wr(FLT, r);
        reg_chk(FLT, r);
        // Burst read walks the pointer across both registers
        host.rd2(TMP, w);
        cmp_reg(w[15:8], 8'h1f);
        cmp_reg(w[7:0], r);
        // Unmapped pointer is acknowledged and reads zero
        reg_wr(8'h2d, 8'h5a);
        reg_chk(8'h2d, 8'h00);
        // Foreign device address: no acknowledge, nothing written
        host.wr(`CFM_I2C_ADDR + 7'h01, FLT, ~r, ack);
        cmp_ack(ack, 1'b0);
        reg_chk(FLT, r);
        // Every event: unmasked rise and fall, masked, then random masks
        for (int pass = 0; pass < 6; pass++) begin
            for (int i = 0; i < `CFM_EV_N; i++) begin
                r = (pass < 2) ? 8'h00 : (pass == 2) ? 8'hff : 8'($urandom);
                reg_wr((i < 5) ? TMP : FLT, r);
                ev_chk(i);
            end
        end
        // Timeout clears only the temperature register
        reg_wr(TMP, 8'h1f);
        reg_wr(FLT, 8'ha5);
        hostCommTimeout <= 1'b1;
        @(posedge ref_clk);
        hostCommTimeout <= 1'b0;
        repeat (2) @(posedge ref_clk);
        reg_chk(TMP, 8'h00);
        reg_chk(FLT, 8'ha5);
        // Register reset clears both
        reg_wr(TMP, 8'h0a);
        softRegReset <= 1'b1;
        @(posedge ref_clk);
        softRegReset <= 1'b0;
        repeat (2) @(posedge ref_clk);
        reg_chk(TMP, 8'h00);
        reg_chk(FLT, 8'h00);
        // Host sets the whole fault mask after the register reset
        reg_wr(FLT, 8'hff);
        reg_chk(FLT, 8'hff);
        complete_run();
    end
endmodule
`default_nettype wire
